/* testbench/bcfa_snd.sv */
// Sounder model: hears beeps and decodes each group.
// Assumes silence longer than a gap ends a group.
`timescale 1ns/1ps
module bcfa_snd #(
  parameter int unsigned LONG_CYC = 8,
  parameter int unsigned GAP_CYC  = 4
)
(
  // Clock, reset, sounder
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       sounder_i,
  // Decoded group
  output logic [3:0]      word_o,
  output logic [3:0]      nbit_o,
  output logic [7:0]      grp_o,
  output logic            tone_o
);
  logic [7:0] hi;
  logic [7:0] lo;
  logic [3:0] sr;
  logic [3:0] nb;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      {hi, lo, sr, nb, word_o, nbit_o, grp_o, tone_o} <= '0;
    end
    else if (sounder_i)
    begin
      hi <= hi + 8'h01;
      lo <= 8'h00;
      tone_o <= tone_o | (hi > LONG_CYC);
    end
    else
    begin
      hi <= 8'h00;
      lo <= lo + 8'h01;
      if (hi != 8'h00)
      begin
        sr <= {sr[2:0], hi >= LONG_CYC};
        nb <= nb + 4'h1;
      end
      if (lo == GAP_CYC && nb != 4'h0)
      begin
        {word_o, nbit_o, nb} <= {sr, nb, 4'h0};
        grp_o <= grp_o + 8'h01;
      end
    end
endmodule

/* testbench/bcfa_sva.sv */
// Assertions on beep timing and code latch.
// Bound to bcfa_top; durations come from its parameters.
`timescale 1ns/1ps
module bcfa_sva #(
  parameter int unsigned LONG_CYC  = 8,
  parameter int unsigned SHORT_CYC = 3,
  parameter int unsigned GAP_CYC   = 4,
  parameter int unsigned PAUSE_CYC = 12
)
(
  // Inputs
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       rom_sum_fail_i,
  input wire logic       bus_fail_i,
  input wire logic       cpu_halt_i,
  // Outputs
  input wire logic       sounder_o,
  input wire logic       active_o,
  input wire logic [3:0] code_o
);
  logic [7:0] hi;
  logic [7:0] lo;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Current high and low run lengths
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i)
      {hi, lo} <= '0;
    else
    begin
      hi <= sounder_o ? hi + 8'h01 : 8'h00;
      lo <= (active_o && !sounder_o) ? lo + 8'h01 : 8'h00;
    end
  a_idle_silent: assert property (!active_o |-> !sounder_o)
    else $error("sound with no code");
  a_beep_len: assert property ($fell(sounder_o) |-> hi == SHORT_CYC || hi == LONG_CYC)
    else $error("bad beep length");
  a_beep_max: assert property (sounder_o && code_o != 4'h8 |-> hi < LONG_CYC)
    else $error("beep too long");
  a_gap_len: assert property ($rose(sounder_o) && $past(active_o) |->
    lo == GAP_CYC || lo == PAUSE_CYC)
    else $error("bad gap length");
  a_tone_hold: assert property (active_o && code_o == 4'h8 |=> sounder_o)
    else $error("tone broke");
  a_code_lock: assert property (active_o |=> active_o && $stable(code_o))
    else $error("code changed");
  a_rom_code: assert property (!active_o && rom_sum_fail_i && !bus_fail_i && !cpu_halt_i
    |=> active_o && code_o == 4'h0)
    else $error("rom code wrong");
  a_bus_tone: assert property ($rose(bus_fail_i) && !active_o |->
    ##[1:6] active_o && code_o == 4'h8)
    else $error("no bus tone");
  c_long: cover property ($fell(sounder_o) && hi == LONG_CYC);
  c_pause: cover property ($rose(sounder_o) && lo == PAUSE_CYC);
  c_tone: cover property (active_o && code_o == 4'h8);
endmodule
bind bcfa_top bcfa_sva #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC), .GAP_CYC(GAP_CYC),
  .PAUSE_CYC(PAUSE_CYC)) bcfa_sva_i (.sys_clk_i, .rstn_i, .rom_sum_fail_i, .bus_fail_i,
  .cpu_halt_i, .sounder_o, .active_o, .code_o);

/* testbench/tb.sv */
// Testbench: every fault code, both tones and the code lock.
// Assumes short sim durations set on bcfa_top.
`timescale 1ns/1ps
module tb;
  logic       sys_clk = 1'b0;
  logic       rstn;
  logic [8:0] f;
  logic       bus_fail;
  logic       cpu_halt;
  logic       os_loading;
  logic       sounder;
  logic       active;
  logic [3:0] code;
  logic [3:0] word;
  logic [3:0] nbit;
  logic [7:0] grp;
  logic       tone;
  int         error_cnt = 0;
  int         compares = 0;
  // Short beep timing for simulation; the sounder model uses its default gap of 4
  localparam int unsigned LONG_CYC  = 8;
  localparam int unsigned SHORT_CYC = 3;
  localparam int unsigned GAP_CYC   = 4;
  localparam int unsigned PAUSE_CYC = 12;
  always #20 sys_clk = ~sys_clk;
  bcfa_top #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC), .GAP_CYC(GAP_CYC),
    .PAUSE_CYC(PAUSE_CYC)) bcfa_top_i (
    .sys_clk_i(sys_clk), .rstn_i(rstn), .rom_sum_fail_i(f[0]), .vid_ctrl_fail_i(f[1]),
    .rtc_stopped_i(f[2]), .sp_ram_fail_i(f[3]), .vid_ram_fail_i(f[4]), .timer_fail_i(f[5]),
    .boot_copy_fail_i(f[6]), .cpu_timeout_i(f[7]), .main_ram_fail_i(f[8]),
    .bus_fail_i(bus_fail), .cpu_halt_i(cpu_halt), .os_loading_i(os_loading),
    .sounder_o(sounder), .active_o(active), .code_o(code));
  bcfa_snd #(.LONG_CYC(LONG_CYC)) bcfa_snd_i (.sys_clk_i(sys_clk), .rstn_i(rstn),
    .sounder_i(sounder), .word_o(word), .nbit_o(nbit), .grp_o(grp), .tone_o(tone));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task start;
    {rstn, f, bus_fail, cpu_halt, os_loading} = '0;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  task wait_grp(input logic [7:0] n);
    for (int i = 0; i < 400 && grp < n; i++)
      @(negedge sys_clk);
  endtask
  task test_codes;
    logic [3:0] exp;
    logic [3:0] pat;
    for (int k = 0; k < 9; k++)
    begin
      exp = (k == 8) ? 4'h9 : k[3:0];
      pat = (k == 8) ? 4'h8 : k[3:0];
      start;
      f[k] = 1'b1;
      @(negedge sys_clk);
      f = '0;
      wait_grp(8'h02);
      chk(word, pat);
      chk(nbit, 4'h4);
      chk(grp, 8'h02);
      chk({active, code}, {1'b1, exp});
    end
    $display("test_codes done");
  endtask
  task test_tone;
    start;
    bus_fail = 1'b1;
    repeat (100) @(negedge sys_clk);
    chk({tone, sounder, code}, 6'h38);
    $display("test_tone done");
  endtask
  task test_halt;
    start;
    cpu_halt = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk(active, 1'b0);
    os_loading = 1'b1;
    repeat (100) @(negedge sys_clk);
    chk({tone, sounder, code}, 6'h38);
    $display("test_halt done");
  endtask
  task test_lock;
    start;
    f = 9'h102;
    @(negedge sys_clk);
    f = 9'h001;
    repeat (5) @(negedge sys_clk);
    f = '0;
    wait_grp(8'h02);
    chk({word, code}, 8'h11);
    $display("test_lock done");
  endtask
  initial
  begin
    test_codes;
    test_tone;
    test_halt;
    test_lock;
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    stop_test;
  end
endmodule

/* verilog/bcfa_cfg.svh */
// Timing and code constants for the beep code fault annunciator.
// Assumes a 25 MHz service processor clock.
`ifndef BCFA_CFG_SVH
`define BCFA_CFG_SVH

`define BCFA_CLK_HZ           25000000
`define BCFA_LONG_MS          600
`define BCFA_SHORT_MS         150
`define BCFA_GAP_MS           200
`define BCFA_PAUSE_MS         1500
`define BCFA_LONG_CYC         ((`BCFA_CLK_HZ / 1000) * `BCFA_LONG_MS)
`define BCFA_SHORT_CYC        ((`BCFA_CLK_HZ / 1000) * `BCFA_SHORT_MS)
`define BCFA_GAP_CYC          ((`BCFA_CLK_HZ / 1000) * `BCFA_GAP_MS)
`define BCFA_PAUSE_CYC        ((`BCFA_CLK_HZ / 1000) * `BCFA_PAUSE_MS)
`define BCFA_CNT_W            32
`define BCFA_CODE_W           4
`define BCFA_BITS_PER_GROUP   3'h4
`define BCFA_MSB_IDX          2'h3
`define BCFA_CODE_ROM         4'h0
`define BCFA_CODE_VIDC        4'h1
`define BCFA_CODE_RTC         4'h2
`define BCFA_CODE_SPRAM       4'h3
`define BCFA_CODE_VRAM        4'h4
`define BCFA_CODE_TIMER       4'h5
`define BCFA_CODE_BOOTCPY     4'h6
`define BCFA_CODE_CPUTO       4'h7
`define BCFA_CODE_BUSFAIL     4'h8
`define BCFA_CODE_MRAM        4'h9
// Code nine beeps long short short short, not its binary value
`define BCFA_PAT_MRAM         4'h8

`endif

/* verilog/bcfa_pkg.sv */
// Types for the beep code fault annunciator.
// Included constants live in bcfa_cfg.svh.
package bcfa_pkg;

  typedef enum logic [2:0] {
    BCFA_IDLE,
    BCFA_BEEP,
    BCFA_GAP,
    BCFA_PAUSE,
    BCFA_TONE
  } bcfa_state_t;

endpackage

/* verilog/bcfa_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to sys_clk_i.
`timescale 1ns/1ps
`include "bcfa_cfg.svh"

module bcfa_sync
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  // Async level in, filtered level out
  input  wire logic async_i,
  output logic      level_o
);

  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb
  begin
    next_level = level_o;
    if (s2 == s3)
    begin
      next_level = s3;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1      <= async_i;
      s2      <= s1;
      s3      <= s2;
      level_o <= next_level;
    end
  end

endmodule

/* verilog/bcfa_top.sv */
// Beep code fault annunciator: turns self-test faults into sounder codes.
// Assumes fault strobes come from logic on sys_clk_i; bus fail and
// processor halt arrive from pins and are synchronised here.
// How it works
// RL1 - A detected fault sounds as a group of exactly four beeps.
// RL2 - Long beep means bit one, short beep means bit zero.
// RL3 - Group repeats forever after a silent pause until power off.
// RL4 - Most significant bit sent first; code one is short short short long.
// RL5 - Boot ROM checksum mismatch reports code zero, four short beeps.
// RL6 - Video controller self-test failure reports code one.
// RL7 - Stopped real time clock reports code two.
// RL8 - Service processor internal memory corruption reports code three.
// RL9 - Video display memory test failure reports code four.
// RL10 - Serial port timer not working reports code five.
// RL11 - Boot code copy mismatch in video memory reports code six.
// RL12 - Main processor handover timeout reports code seven.
// RL13 - Expansion bus fail line reports code eight as continuous tone; the code gives it only from idle, never once a fault group has started.
// RL14 - Main memory test failure reports code nine, beeped long short short short.
// RL15 - Main processor halting after OS load gives continuous tone; the code gives it only from idle, never once a fault group has started.
// RL16 - Beep, gap and pause lengths are clock-cycle parameters.
`timescale 1ns/1ps
`include "bcfa_cfg.svh"

module bcfa_top
  import bcfa_pkg::*;
#(
  // RL16 durations in cycles
  parameter int unsigned LONG_CYC  = `BCFA_LONG_CYC,
  parameter int unsigned SHORT_CYC = `BCFA_SHORT_CYC,
  parameter int unsigned GAP_CYC   = `BCFA_GAP_CYC,
  parameter int unsigned PAUSE_CYC = `BCFA_PAUSE_CYC
)
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // Self-test fault strobes, same clock domain
  input  wire logic       rom_sum_fail_i,
  input  wire logic       vid_ctrl_fail_i,
  input  wire logic       rtc_stopped_i,
  input  wire logic       sp_ram_fail_i,
  input  wire logic       vid_ram_fail_i,
  input  wire logic       timer_fail_i,
  input  wire logic       boot_copy_fail_i,
  input  wire logic       cpu_timeout_i,
  input  wire logic       main_ram_fail_i,
  // Pin inputs from outside the clock domain
  input  wire logic       bus_fail_i,
  input  wire logic       cpu_halt_i,
  input  wire logic       os_loading_i,
  // Sounder and status
  output logic            sounder_o,
  output logic            active_o,
  output logic [3:0]      code_o
);

  logic              bus_fail;
  logic              cpu_halt;
  logic              os_loading;
  bcfa_state_t       state;
  bcfa_state_t       next_state;
  logic [3:0]        code;
  logic [3:0]        next_code;
  logic [1:0]        bit_idx;
  logic [1:0]        next_bit_idx;
  logic [31:0]       cnt;
  logic [31:0]       next_cnt;
  logic              fault_hit;
  logic [3:0]        fault_code;
  logic [3:0]        beep_pat;
  logic              cur_bit;

  bcfa_sync u_sync_fail
  (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (bus_fail_i),
    .level_o   (bus_fail)
  );

  bcfa_sync u_sync_halt
  (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (cpu_halt_i),
    .level_o   (cpu_halt)
  );

  bcfa_sync u_sync_load
  (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (os_loading_i),
    .level_o   (os_loading)
  );

  // Fault to code mapping, lowest code wins on ties
  always_comb
  begin
    fault_hit  = 1'b1;
    fault_code = `BCFA_CODE_ROM;
    // RL5 checksum code
    if (rom_sum_fail_i)
    begin
      fault_code = `BCFA_CODE_ROM;
    end
    // RL6 video controller
    else if (vid_ctrl_fail_i)
    begin
      fault_code = `BCFA_CODE_VIDC;
    end
    // RL7 clock stopped
    else if (rtc_stopped_i)
    begin
      fault_code = `BCFA_CODE_RTC;
    end
    // RL8 internal memory
    else if (sp_ram_fail_i)
    begin
      fault_code = `BCFA_CODE_SPRAM;
    end
    // RL9 video memory
    else if (vid_ram_fail_i)
    begin
      fault_code = `BCFA_CODE_VRAM;
    end
    // RL10 serial timer
    else if (timer_fail_i)
    begin
      fault_code = `BCFA_CODE_TIMER;
    end
    // RL11 boot copy compare
    else if (boot_copy_fail_i)
    begin
      fault_code = `BCFA_CODE_BOOTCPY;
    end
    // RL12 handover timeout
    else if (cpu_timeout_i)
    begin
      fault_code = `BCFA_CODE_CPUTO;
    end
    // RL14 main memory
    else if (main_ram_fail_i)
    begin
      fault_code = `BCFA_CODE_MRAM;
    end
    else
    begin
      fault_hit = 1'b0;
    end
  end

  // RL14 code nine pattern
  assign beep_pat = (code == `BCFA_CODE_MRAM) ? `BCFA_PAT_MRAM : code;

  // RL4 msb first
  assign cur_bit = beep_pat[bit_idx];

  always_comb
  begin
    next_state   = state;
    next_code    = code;
    next_bit_idx = bit_idx;
    next_cnt     = cnt;
    unique case (state)
      BCFA_IDLE:
      begin
        // RL13 bus fail tone
        if (bus_fail)
        begin
          next_state = BCFA_TONE;
          next_code  = `BCFA_CODE_BUSFAIL;
        end
        // RL15 halt after load
        else if (cpu_halt && os_loading)
        begin
          next_state = BCFA_TONE;
          next_code  = `BCFA_CODE_BUSFAIL;
        end
        // RL1 start group
        else if (fault_hit)
        begin
          next_state   = BCFA_BEEP;
          next_code    = fault_code;
          next_bit_idx = `BCFA_MSB_IDX;
          next_cnt     = '0;
        end
      end
      BCFA_BEEP:
      begin
        next_cnt = cnt + 32'h1;
        // RL2 long for one
        if ((cur_bit && (cnt >= LONG_CYC - 1)) || (!cur_bit && (cnt >= SHORT_CYC - 1)))
        begin
          next_cnt = '0;
          next_state = (bit_idx == 2'h0) ? BCFA_PAUSE : BCFA_GAP;
        end
      end
      BCFA_GAP:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt >= GAP_CYC - 1)
        begin
          next_cnt     = '0;
          next_bit_idx = bit_idx - 2'h1;
          next_state   = BCFA_BEEP;
        end
      end
      BCFA_PAUSE:
      begin
        next_cnt = cnt + 32'h1;
        // RL3 replay forever
        if (cnt >= PAUSE_CYC - 1)
        begin
          next_cnt     = '0;
          next_bit_idx = `BCFA_MSB_IDX;
          next_state   = BCFA_BEEP;
        end
      end
      BCFA_TONE:
      begin
        next_state = BCFA_TONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state   <= BCFA_IDLE;
      code    <= 4'h0;
      bit_idx <= 2'h0;
      cnt     <= 32'h0;
    end
    else
    begin
      state   <= next_state;
      code    <= next_code;
      bit_idx <= next_bit_idx;
      cnt     <= next_cnt;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sounder_o <= 1'b0;
      active_o  <= 1'b0;
      code_o    <= 4'h0;
    end
    else
    begin
      sounder_o <= (next_state == BCFA_BEEP) || (next_state == BCFA_TONE);
      active_o  <= (next_state != BCFA_IDLE);
      code_o    <= next_code;
    end
  end

endmodule
